// >>> fbio_regs.vh
/*
 * Register indices, field positions, reset values and timing counts of
 * the four-bit port with wake-up.
 * Assumes a 50 MHz system clock and AXI4-Lite byte addresses equal to
 * four times the register index.
 */
`ifndef FBIO_REGS_VH
`define FBIO_REGS_VH

// Register indices, byte address is index times four
`define FBIO_IDX_DIR 6'h02
`define FBIO_IDX_DATA 6'h03
`define FBIO_IDX_OPT 6'h10
`define FBIO_IDX_PDSEL 6'h11
`define FBIO_IDX_HALT 6'h12
`define FBIO_IDX_STAT 6'h13
`define FBIO_IDX_MASK 6'h14
`define FBIO_IDX_PIN 6'h15

// Option register fields
`define FBIO_OPT_WAKE_LO 0
`define FBIO_OPT_WAKE_HI 3
`define FBIO_OPT_DUAL 4
`define FBIO_OPT_IR 5
`define FBIO_OPT_LOWPD 6
`define FBIO_OPT_AMP 7
`define FBIO_OPT_RC 8
`define FBIO_OPT_W 9

// Pull-down selection fields
`define FBIO_PD_HIGH_LO 0
`define FBIO_PD_HIGH_HI 3
`define FBIO_PD_MID_LO 4
`define FBIO_PD_MID_HI 7

// Status and mask fields
`define FBIO_ST_WAKE 0
`define FBIO_ST_EDGE 1
`define FBIO_ST_W 2

// Reset values
`define FBIO_DIR_RST 4'h0
`define FBIO_DATA_RST 4'h0
`define FBIO_OPT_RST 9'h000
`define FBIO_PDSEL_RST 8'h00
`define FBIO_WAKE_ADDR 12'h004

// AXI responses
`define FBIO_RESP_OKAY 2'h0
`define FBIO_RESP_SLVERR 2'h2

// Carrier timing
`define FBIO_CLK_HZ 50000000
`define FBIO_IR_HZ 38000
`define FBIO_IR_HALF (`FBIO_CLK_HZ / (2 * `FBIO_IR_HZ))

`endif

// >>> fbio_sync.v
/*
 * Two-stage synchroniser for a group of input levels.
 * Assumes inputs may change at any time relative to clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none

module fbio_sync #(
  parameter WIDTH = 4
) (
  input wire clk_sys,
  input wire srst,
  input wire [WIDTH-1:0] async_i,
  output reg [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always @(posedge clk_sys) begin
    if (srst) begin
      meta_q <= {WIDTH{1'b0}};
      sync_o <= {WIDTH{1'b0}};
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule

`default_nettype wire

// >>> fbio_port.v
/*
 * Four-bit bidirectional port with per-pin direction, pull-down control,
 * pin wake-up from halt, infrared carrier on the top pin and analog wake
 * enables on the lowest pin, reached over an AXI4-Lite slave.
 * Assumes one 50 MHz clock, a synchronous active-high reset, and that the
 * pad ring resolves pin level from pin_o and pin_oe.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fbio_regs.vh"

module fbio_port #(
  parameter ADDR_W = 8,
  parameter [`FBIO_OPT_W-1:0] OPT_RESET = `FBIO_OPT_RST,
  parameter [7:0] PDSEL_RESET = `FBIO_PDSEL_RST
) (
  input wire clk_sys,
  input wire srst,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [3:0] pin_i,
  output reg [3:0] pin_o,
  output reg [3:0] pin_oe,
  output reg [3:0] pd_high_en,
  output reg [3:0] pd_mid_en,
  output reg [3:0] pd_low_en,
  output reg schmitt_wake_en,
  output reg amp_wake_en,
  output reg osc_run,
  output reg wake_pulse,
  output reg [11:0] wake_addr,
  output reg irq
);

  localparam integer IR_HALF_I = `FBIO_IR_HALF;
  localparam [9:0] IR_HALF = IR_HALF_I[9:0];

  reg [3:0] dir_q;
  reg [3:0] data_q;
  reg [`FBIO_OPT_W-1:0] opt_q;
  reg [7:0] pdsel_q;
  reg halted_q;
  reg [`FBIO_ST_W-1:0] stat_q;
  reg [`FBIO_ST_W-1:0] stat_d;
  reg [`FBIO_ST_W-1:0] mask_q;
  reg [3:0] pin_prev_q;
  reg [9:0] ir_cnt_q;
  reg ir_wave_q;
  reg aw_full_q;
  reg w_full_q;
  reg [ADDR_W-1:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg [31:0] rd_data;
  reg rd_ok;
  reg [3:0] oe_d;
  reg [3:0] out_d;
  reg [3:0] pd_keep;

  wire [3:0] pin_s;
  wire [5:0] wr_idx;
  wire [5:0] rd_idx;
  wire wr_go;
  wire wr_en;
  wire [3:0] port_read;
  wire [3:0] rise;
  wire [3:0] fall;
  wire [3:0] wake_edges;
  wire wake_hit;
  wire [3:0] wake_en;
  wire dual_opt;
  wire ir_opt;
  wire lowpd_opt;
  wire amp_opt;
  wire rc_opt;

  assign wake_en = opt_q[`FBIO_OPT_WAKE_HI:`FBIO_OPT_WAKE_LO];
  assign dual_opt = opt_q[`FBIO_OPT_DUAL];
  assign ir_opt = opt_q[`FBIO_OPT_IR];
  assign lowpd_opt = opt_q[`FBIO_OPT_LOWPD];
  assign amp_opt = opt_q[`FBIO_OPT_AMP];
  assign rc_opt = opt_q[`FBIO_OPT_RC];

  // Pin levels are only used after the synchroniser
  fbio_sync #(
    .WIDTH(4)
  ) u_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .async_i(pin_i),
    .sync_o(pin_s)
  );

  // Output bits show the latch, input bits the synchronised pin
  assign port_read = (dir_q & data_q) | (~dir_q & pin_s);

  // Edge detection on synchronised levels
  assign rise = pin_s & ~pin_prev_q;
  assign fall = ~pin_s & pin_prev_q;
  assign wake_edges = wake_en & (rise | (dual_opt ? fall : 4'h0));
  assign wake_hit = |wake_edges;

  // Write channel: address and data may arrive in either order
  assign wr_go = aw_full_q & w_full_q & ~s_axi_bvalid;
  assign wr_idx = awaddr_q[7:2];
  assign wr_en = wr_go & wstrb_q[0];

  always @(posedge clk_sys) begin
    if (srst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FBIO_RESP_OKAY;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= {ADDR_W{1'b0}};
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (wr_idx == `FBIO_IDX_DIR || wr_idx == `FBIO_IDX_DATA ||
            wr_idx == `FBIO_IDX_OPT || wr_idx == `FBIO_IDX_PDSEL ||
            wr_idx == `FBIO_IDX_HALT || wr_idx == `FBIO_IDX_STAT ||
            wr_idx == `FBIO_IDX_MASK || wr_idx == `FBIO_IDX_PIN) begin
          s_axi_bresp <= `FBIO_RESP_OKAY;
        end else begin
          s_axi_bresp <= `FBIO_RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read decode
  assign rd_idx = s_axi_araddr[7:2];

  always @* begin
    rd_data = 32'h00000000;
    rd_ok = 1'b1;
    if (rd_idx == `FBIO_IDX_DIR) begin
      rd_data[3:0] = dir_q;
    end else if (rd_idx == `FBIO_IDX_DATA) begin
      rd_data[3:0] = port_read;
    end else if (rd_idx == `FBIO_IDX_OPT) begin
      rd_data[`FBIO_OPT_W-1:0] = opt_q;
    end else if (rd_idx == `FBIO_IDX_PDSEL) begin
      rd_data[7:0] = pdsel_q;
    end else if (rd_idx == `FBIO_IDX_HALT) begin
      rd_data[0] = halted_q;
    end else if (rd_idx == `FBIO_IDX_STAT) begin
      rd_data[`FBIO_ST_W-1:0] = stat_q;
    end else if (rd_idx == `FBIO_IDX_MASK) begin
      rd_data[`FBIO_ST_W-1:0] = mask_q;
    end else if (rd_idx == `FBIO_IDX_PIN) begin
      rd_data[3:0] = pin_s;
    end else begin
      rd_ok = 1'b0;
    end
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `FBIO_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_ok ? `FBIO_RESP_OKAY : `FBIO_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Status: a new event wins over a write-one clear in the same cycle
  always @* begin
    stat_d = stat_q;
    if (wr_en && wr_idx == `FBIO_IDX_STAT) begin
      stat_d = stat_q & ~wdata_q[`FBIO_ST_W-1:0];
    end
    if (halted_q && wake_hit) begin
      stat_d[`FBIO_ST_WAKE] = 1'b1;
    end
    if (wake_hit) begin
      stat_d[`FBIO_ST_EDGE] = 1'b1;
    end
  end

  // Software-visible registers and halt state
  always @(posedge clk_sys) begin
    if (srst) begin
      dir_q <= `FBIO_DIR_RST;
      data_q <= `FBIO_DATA_RST;
      opt_q <= OPT_RESET;
      pdsel_q <= PDSEL_RESET;
      halted_q <= 1'b0;
      stat_q <= {`FBIO_ST_W{1'b0}};
      mask_q <= {`FBIO_ST_W{1'b0}};
      pin_prev_q <= 4'h0;
    end else begin
      pin_prev_q <= pin_s;
      stat_q <= stat_d;
      if (wr_en && wr_idx == `FBIO_IDX_DIR) begin
        dir_q <= wdata_q[3:0];
      end
      if (wr_en && wr_idx == `FBIO_IDX_DATA) begin
        data_q <= wdata_q[3:0];
      end
      // RC wake bit acts as a fuse: set only by OPT_RESET
      if (wr_en && wr_idx == `FBIO_IDX_OPT) begin
        opt_q[7:0] <= wdata_q[7:0];
      end
      if (wr_en && wr_idx == `FBIO_IDX_PDSEL) begin
        pdsel_q <= wdata_q[7:0];
      end
      if (wr_en && wr_idx == `FBIO_IDX_MASK) begin
        mask_q <= wdata_q[`FBIO_ST_W-1:0];
      end
      // A wake edge ends a halt only when already halted; a halt request with an edge in the same cycle still halts
      if (halted_q && wake_hit) begin
        halted_q <= 1'b0;
      end else if (wr_en && wr_idx == `FBIO_IDX_HALT && wdata_q[0]) begin
        halted_q <= 1'b1;
      end
    end
  end

  // Carrier runs free, so the first half-period after enabling can be shorter than IR_HALF
  always @(posedge clk_sys) begin
    if (srst) begin
      ir_cnt_q <= 10'h000;
      ir_wave_q <= 1'b0;
    end else if (ir_cnt_q == IR_HALF - 10'h001) begin
      ir_cnt_q <= 10'h000;
      ir_wave_q <= ~ir_wave_q;
    end else begin
      ir_cnt_q <= ir_cnt_q + 10'h001;
    end
  end

  // Pin drive
  always @* begin
    oe_d = dir_q;
    out_d = data_q & dir_q;
    if (ir_opt) begin
      if (halted_q) begin
        oe_d[3] = 1'b1;
        out_d[3] = 1'b0;
      end else if (dir_q[3]) begin
        out_d[3] = data_q[3] ? ir_wave_q : 1'b0;
      end
    end
    // Without the option bit 3 keeps the plain assignment above
  end

  // Pull-downs only on pins that are not driven
  always @* begin
    pd_keep = ~oe_d;
    if (amp_opt) begin
      pd_keep[0] = 1'b0;
    end
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      pin_o <= 4'h0;
      pin_oe <= 4'h0;
      pd_high_en <= 4'h0;
      pd_mid_en <= 4'h0;
      pd_low_en <= 4'h0;
      schmitt_wake_en <= 1'b0;
      amp_wake_en <= 1'b0;
      osc_run <= 1'b1;
      wake_pulse <= 1'b0;
      wake_addr <= `FBIO_WAKE_ADDR;
      irq <= 1'b0;
    end else begin
      pin_o <= out_d;
      pin_oe <= oe_d;
      pd_high_en <= pd_keep &
        pdsel_q[`FBIO_PD_HIGH_HI:`FBIO_PD_HIGH_LO];
      pd_mid_en <= pd_keep & (lowpd_opt ? 4'h0 :
        pdsel_q[`FBIO_PD_MID_HI:`FBIO_PD_MID_LO]);
      pd_low_en <= pd_keep & (lowpd_opt ?
        pdsel_q[`FBIO_PD_MID_HI:`FBIO_PD_MID_LO] : 4'h0);
      // Follows the option from the first cycle after reset
      schmitt_wake_en <= rc_opt;
      amp_wake_en <= amp_opt;
      osc_run <= ~(halted_q & ~wake_hit);
      wake_pulse <= halted_q & wake_hit;
      wake_addr <= `FBIO_WAKE_ADDR;
      irq <= |(stat_d & mask_q);
    end
  end

endmodule

`default_nettype wire

// >>> fbio_pads.sv
/* Far-side pad model for the four port pins.
   Assumes the device side wins wherever its pin_oe is high. */
`timescale 1ns/1ps
`default_nettype none
module fbio_pads (
  input wire logic clk_sys,
  input wire logic [3:0] pin_o,
  input wire logic [3:0] pin_oe,
  input wire logic [3:0] pd_on,
  input wire logic [3:0] ext_en,
  input wire logic [3:0] ext_val,
  output logic [3:0] pin_i
);
  logic [3:0] flt_q = 4'h5;
  // An open line with no pull-down wanders, so reads never look settled
  always @(posedge clk_sys) begin
    flt_q <= ~flt_q;
  end
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_val) |
    (~pin_oe & ~ext_en & ~pd_on & flt_q);
endmodule
`default_nettype wire

// >>> fbio_port_monitor.sv
/* Port checker for the four-bit port.
   Assumes one clock and the bind below onto every fbio_port. */
`timescale 1ns/1ps
`default_nettype none
module fbio_port_monitor (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] pin_oe,
  input wire logic [3:0] pd_high_en,
  input wire logic [3:0] pd_mid_en,
  input wire logic [3:0] pd_low_en,
  input wire logic schmitt_wake_en,
  input wire logic amp_wake_en,
  input wire logic osc_run,
  input wire logic wake_pulse,
  input wire logic [11:0] wake_addr
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  wire logic [3:0] pd_any;
  assign pd_any = pd_high_en | pd_mid_en | pd_low_en;
  a_dir_reset: assert property ($fell(srst) |-> pin_oe == 4'h0)
    else $error("Pin driven after reset");
  a_out_pd_off: assert property ((pin_oe & pd_any) == 4'h0)
    else $error("Pull-down on driven pin");
  // Two cycles of slack: the option and the pull-downs are separate flops
  a_amp_pd_off: assert property (amp_wake_en && $past(amp_wake_en, 2)
    |-> !pd_any[0])
    else $error("Pull-down on lowest pin in amp mode");
  a_wake_vector: assert property (wake_pulse |-> wake_addr == 12'h004)
    else $error("Wrong wake address");
  a_wake_osc: assert property ($rose(osc_run) |-> wake_pulse)
    else $error("Oscillator restart without wake");
  a_wake_single: assert property (wake_pulse |=> !wake_pulse && osc_run)
    else $error("Wake pulse too long");
  // The enable loads from the option one edge after release
  a_rc_steady: assert property (!$past(srst) && !$past(srst, 2) |->
    $stable(schmitt_wake_en))
    else $error("Schmitt enable moved");
  a_b_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("Write response repeated");
  a_r_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("Read response repeated");
  c_wake: cover property (wake_pulse);
  c_halt: cover property (!osc_run);
  c_amp: cover property (amp_wake_en);
endmodule
bind fbio_port fbio_port_monitor fbio_port_monitor_i (.*);
`default_nettype wire

// >>> fbio_port_test.sv
/* Self-checking bench of the four-bit port with wake-up.
   Assumes fbio_pads as far side and the monitor bound by itself. */
`timescale 1ns/1ps
`default_nettype none
`include "fbio_regs.vh"
module fbio_port_test;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, rd_q;
  logic [31:0] seed = 32'h0001414A;
  logic [3:0] ext_en = 4'hF, ext_val = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic irq, osc_run, wake_pulse, schmitt_wake_en, amp_wake_en;
  logic [1:0] bresp, rresp, rsp;
  logic [3:0] pin_i, pin_o, pin_oe, pdh, pdm, pdl;
  logic [11:0] wake_addr;
  integer fail_count = 0, compares = 0;
  integer n, k, lv, m_dir, m_dat, m_pd, m_opt, hi, md;
  always #10 clk_sys = ~clk_sys;
  fbio_port #(.OPT_RESET(9'h100)) fbio_port_i (
    .clk_sys(clk_sys), .srst(srst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe(pin_oe), .pd_high_en(pdh), .pd_mid_en(pdm),
    .pd_low_en(pdl), .schmitt_wake_en(schmitt_wake_en),
    .amp_wake_en(amp_wake_en), .osc_run(osc_run),
    .wake_pulse(wake_pulse), .wake_addr(wake_addr), .irq(irq));
  fbio_pads fbio_pads_i (.clk_sys(clk_sys), .pin_o(pin_o),
    .pin_oe(pin_oe), .pd_on(pdh | pdm | pdl), .ext_en(ext_en),
    .ext_val(ext_val), .pin_i(pin_i));
  function automatic [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input [31:0] seen, input [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task finish_test;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Called right after a clock edge; bready is held high throughout
  task wr(input [5:0] a, input [31:0] d);
    awaddr <= {a, 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    if (bvalid !== 1'b1) begin
      fail_count++;
    end
    rsp = bresp;
  endtask
  task rd(input [5:0] a);
    araddr <= {a, 2'b00};
    arvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    if (rvalid !== 1'b1) begin
      fail_count++;
    end
    rd_q = rdata;
    rsp = rresp;
  endtask
  task flip;
    lv = pin_o[3];
    n = 0;
    while (pin_o[3] === lv[0] && n < 2000) begin
      @(posedge clk_sys);
      n++;
    end
    if (pin_o[3] === lv[0]) begin
      fail_count++;
    end
  endtask
  task pause(input integer c);
    repeat (c) @(posedge clk_sys);
  endtask
  initial begin
    repeat (30000) @(posedge clk_sys);
    fail_count++;
    finish_test;
  end
  initial begin
    pause(8);
    srst <= 1'b0;
    pause(1);
    rd(`FBIO_IDX_DIR);
    chk(rd_q, 0);
    chk(32'(pin_oe), 0);
    chk(32'(schmitt_wake_en), 1);
    chk(32'(amp_wake_en), 0);
    rd(6'h3F);
    chk(32'(rsp), 32'(`FBIO_RESP_SLVERR));
    chk(rd_q, 0);
    wr(6'h3F, 32'h0000000F);
    chk(32'(rsp), 32'(`FBIO_RESP_SLVERR));
    wr(`FBIO_IDX_DIR, 0);
    chk(32'(rsp), 32'(`FBIO_RESP_OKAY));
    chk(32'(pin_oe), 0);
    $display("reset test done");
    for (k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      m_dir = seed[3:0];
      m_dat = seed[7:4];
      m_pd = seed[15:8];
      m_opt = 'h100 | ((k % 4) << 6);
      ext_val <= seed[19:16];
      ext_en <= ~seed[3:0];
      wr(`FBIO_IDX_OPT, m_opt);
      wr(`FBIO_IDX_PDSEL, m_pd);
      wr(`FBIO_IDX_DIR, m_dir);
      wr(`FBIO_IDX_DATA, m_dat);
      pause(4);
      rd(`FBIO_IDX_DATA);
      chk(rd_q, (m_dat & m_dir) | (seed[19:16] & ~m_dir & 15));
      rd(`FBIO_IDX_PIN);
      chk(rd_q, (m_dat & m_dir) | (seed[19:16] & ~m_dir & 15));
      chk(32'(pin_oe), m_dir);
      chk(32'(pin_o & pin_oe), m_dat & m_dir);
      hi = m_pd & ~m_dir & 15;
      md = (m_pd >> 4) & ~m_dir & 15;
      if (m_opt & 'h80) begin
        hi = hi & 14;
        md = md & 14;
      end
      chk(32'(pdh), hi);
      chk(32'(pdl), (m_opt & 'h40) ? md : 0);
      chk(32'(pdm), (m_opt & 'h40) ? 0 : md);
      chk(32'(amp_wake_en), (m_opt >> 7) & 1);
    end
    $display("port test done");
    ext_en <= 4'hF;
    ext_val <= 4'h0;
    wr(`FBIO_IDX_DIR, 0);
    for (k = 0; k < 2; k++) begin
      wr(`FBIO_IDX_OPT, 'h102 | (k << 4));
      wr(`FBIO_IDX_MASK, k ? 0 : 1);
      ext_val <= 4'h2;
      pause(6);
      wr(`FBIO_IDX_STAT, 3);
      wr(`FBIO_IDX_HALT, 1);
      pause(2);
      chk(32'(osc_run), 0);
      ext_val <= 4'h6;
      pause(8);
      chk(32'(osc_run), 0);
      ext_val <= 4'h4;
      pause(8);
      chk(32'(osc_run), k);
      ext_val <= 4'h6;
      pause(8);
      chk(32'(osc_run), 1);
      chk(32'(wake_addr), 32'h004);
      chk(32'(irq), k ? 0 : 1);
      rd(`FBIO_IDX_STAT);
      chk(rd_q & 1, 1);
      wr(`FBIO_IDX_STAT, 1);
      pause(2);
      chk(32'(irq), 0);
      ext_val <= 4'h0;
      pause(6);
    end
    $display("wake test done");
    wr(`FBIO_IDX_OPT, 'h120);
    wr(`FBIO_IDX_DIR, 8);
    wr(`FBIO_IDX_DATA, 8);
    flip();
    flip();
    chk(n, `FBIO_IR_HALF);
    wr(`FBIO_IDX_DATA, 0);
    pause(2);
    chk(32'({pin_oe[3], pin_o[3]}), 2);
    wr(`FBIO_IDX_DATA, 8);
    wr(`FBIO_IDX_DIR, 0);
    wr(`FBIO_IDX_HALT, 1);
    pause(2);
    chk(32'({pin_oe[3], pin_o[3]}), 2);
    rd(`FBIO_IDX_HALT);
    chk(rd_q, 1);
    srst <= 1'b1;
    pause(8);
    srst <= 1'b0;
    pause(1);
    chk(32'({osc_run, pin_oe}), 'h10);
    $display("carrier test done");
    finish_test;
  end
endmodule
`default_nettype wire
